// File: hdl/sspe_consts.svh
// Constants for the strap sampling and power enable block
`ifndef SSPE_CONSTS_SVH
`define SSPE_CONSTS_SVH

// Timing
`define SSPE_CLK_MHZ 100
`define SSPE_SAMPLE_DELAY_US 2000

// Strap pad positions
`define SSPE_PAD_W 9
`define SSPE_GPIO_W 8
`define SSPE_PAD_LVL_LO 0
`define SSPE_PAD_LVL_HI 1
`define SSPE_PAD_HOST_LO 2
`define SSPE_PAD_HOST_HI 3
`define SSPE_PAD_FUSE 4
`define SSPE_PAD_FLASH_PRES 5
`define SSPE_PAD_REMAP 6
`define SSPE_PAD_FLASH_VEND 7
`define SSPE_PAD_XTAL 8
`define SSPE_STRAP_DEFAULTS 9'h052

// Strap encodings
`define SSPE_HOST_USB 2'h0
`define SSPE_HOST_USB_NOBOOT 2'h1
`define SSPE_LVL_NONE 2'h0

// Register offsets
`define SSPE_OFF_STATUS 8'h00
`define SSPE_OFF_CTRL 8'h04
`define SSPE_OFF_GPIO_OUT 8'h08
`define SSPE_OFF_GPIO_OE 8'h0c
`define SSPE_OFF_GPIO_IN 8'h10
`define SSPE_OFF_PWR 8'h14
`define SSPE_HSIZE_WORD 3'h2

// Control register
`define SSPE_CTRL_W 4
`define SSPE_CTRL_PD_SRR 0
`define SSPE_CTRL_PD_WLAN 1
`define SSPE_CTRL_OSC_REQ 2
`define SSPE_CTRL_CPU_RUN 3
`define SSPE_CTRL_RESET 4'h3

// Power channels
`define SSPE_NCH 2
`define SSPE_CH_SRR 0
`define SSPE_CH_WLAN 1

`endif

// File: hdl/sspe_pkg.sv
// Types for the strap sampling and power enable block
`default_nettype none
package sspe_pkg;
  typedef enum logic [2:0] {
    sspe_st_wait = 3'b001,
    sspe_st_count = 3'b010,
    sspe_st_done = 3'b100
  } sspe_state_t;
  typedef logic [8:0] sspe_pad_t;
endpackage
`default_nettype wire

// File: hdl/sspe_power_gate.sv
// One section power enable with regulator and section reset control
`timescale 1ns/100ps
`default_nettype none
module sspe_power_gate (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic pwr_en_i,
  input wire logic pd_cfg_i,
  output logic reg_en_o,
  output logic section_rst_n_o,
  output logic pd_en_o
);

  // ****************************************
  // Regulator, reset and pull-down
  // ****************************************
  // Reset lifts one cycle after the regulator so the section never runs unpowered
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      reg_en_o <= 1'b0;
      section_rst_n_o <= 1'b0;
      pd_en_o <= 1'b1;
    end else if (clk_en_i) begin
      reg_en_o <= pwr_en_i;
      section_rst_n_o <= pwr_en_i && reg_en_o;
      pd_en_o <= pd_cfg_i;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i iff clk_en_i);
  endclocking
  default disable iff (!resetn_i);

  gate_off_a: assert property (
    !pwr_en_i |=> !reg_en_o && !section_rst_n_o)
    else $error("section not held off while enable low");
  release_order_a: assert property (
    $rose(section_rst_n_o) |-> reg_en_o && $past(reg_en_o))
    else $error("section reset released before regulator");
  power_up_c: cover property ($rose(section_rst_n_o));

endmodule // sspe_power_gate
`default_nettype wire

// File: hdl/sspe_top.sv
// Strap sampling and power enable top with AHB-Lite register slave
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Summary of operation
// - Straps sampled once, a set delay after reset or external reset release.
// - After sampling, strap pads become GPIO or oscillator enable output.
// - Host select strap: 00 normal USB, 01 USB without bootloader.
// - Fuse power strap 0 leaves fuse memory unpowered; default 1.
// - Flash present strap and flash vendor strap, both default 0.
// - Remap strap: 0 SRAM, 1 ROM boot; processor held in reset.
// - Resource level strap sets clock bring-up level; default 10.
// - Polarity strap: 0 oscillator enable active high, 1 active low.
// - Radio enable powers its regulators and holds section reset while low.
// - WLAN enable powers its regulators and holds section reset while low.
// ****************************************
`include "sspe_consts.svh"

module sspe_top #(
  parameter int unsigned SAMPLE_DELAY_CYCLES = `SSPE_SAMPLE_DELAY_US * `SSPE_CLK_MHZ
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic ext_por_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Strap pads
  input wire logic [`SSPE_PAD_W-1:0] pad_i,
  output logic [`SSPE_PAD_W-1:0] pad_o,
  output logic [`SSPE_PAD_W-1:0] pad_oe_o,
  output logic [`SSPE_PAD_W-1:0] pad_pu_o,
  output logic [`SSPE_PAD_W-1:0] pad_pd_o,
  // Decoded straps
  output logic straps_valid_o,
  output logic [1:0] host_ifc_mode_o,
  output logic bootloader_skip_o,
  output logic fuse_mem_power_o,
  output logic flash_present_o,
  output logic flash_vendor_o,
  output logic boot_from_rom_o,
  output logic cpu_hold_reset_o,
  output logic [1:0] resource_level_o,
  // Section power
  input wire logic short_range_radio_power_enable_i,
  input wire logic wireless_lan_power_enable_i,
  output logic [`SSPE_NCH-1:0] reg_en_o,
  output logic [`SSPE_NCH-1:0] section_rst_n_o,
  output logic [`SSPE_NCH-1:0] pwr_pd_en_o
);

  localparam int unsigned CW = $clog2(SAMPLE_DELAY_CYCLES + 1);

  // ****************************************
  // Strap sampling sequencer
  // ****************************************
  sspe_pkg::sspe_state_t state;
  sspe_pkg::sspe_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  sspe_pkg::sspe_pad_t strap_q;
  sspe_pkg::sspe_pad_t next_straps;
  logic next_valid;

  wire por_active = !ext_por_n_i;
  wire in_count = (state == sspe_pkg::sspe_st_count);
  wire in_done = (state == sspe_pkg::sspe_st_done);
  wire cnt_last = (cnt == CW'(SAMPLE_DELAY_CYCLES - 1));
  wire sample_now = in_count && cnt_last && !por_active;

  // External reset restarts the wait, as a fresh power-on would
  always_comb begin
    next_state = state;
    case (state)
      sspe_pkg::sspe_st_wait: begin
        if (!por_active) begin
          next_state = sspe_pkg::sspe_st_count;
        end
      end
      sspe_pkg::sspe_st_count: begin
        if (por_active) begin
          next_state = sspe_pkg::sspe_st_wait;
        end else if (cnt_last) begin
          next_state = sspe_pkg::sspe_st_done;
        end
      end
      sspe_pkg::sspe_st_done: begin
        if (por_active) begin
          next_state = sspe_pkg::sspe_st_wait;
        end
      end
      default: begin
        next_state = sspe_pkg::sspe_st_wait;
      end
    endcase
  end

  // Count clears outside its state, so a restart always waits the full delay
  assign next_cnt = (in_count && !cnt_last && !por_active) ? cnt + CW'(1) : '0;
  // Straps change only at the sampling instant
  assign next_straps = sample_now ? pad_i : strap_q;
  assign next_valid = !por_active && (sample_now || in_done);

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state <= sspe_pkg::sspe_st_wait;
      cnt <= '0;
      strap_q <= `SSPE_STRAP_DEFAULTS;
    end else if (clk_en_i) begin
      state <= next_state;
      cnt <= next_cnt;
      strap_q <= next_straps;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [`SSPE_CTRL_W-1:0] ctrl;
  logic [`SSPE_GPIO_W-1:0] gpio_out;
  logic [`SSPE_GPIO_W-1:0] gpio_oe;
  logic wr_pend;
  logic [7:0] wr_off;
  logic [31:0] rd_mux;

  wire addr_ph = hsel_i && hready_i && htrans_i[1];
  wire [7:0] a_off = haddr_i[7:0];
  wire wr_take = addr_ph && hwrite_i && (hsize_i == `SSPE_HSIZE_WORD);
  wire wr_ctrl = wr_pend && (wr_off == `SSPE_OFF_CTRL);
  wire wr_gout = wr_pend && (wr_off == `SSPE_OFF_GPIO_OUT);
  wire wr_goe = wr_pend && (wr_off == `SSPE_OFF_GPIO_OE);
  wire osc_req = ctrl[`SSPE_CTRL_OSC_REQ];
  wire cpu_run = ctrl[`SSPE_CTRL_CPU_RUN];
  wire [`SSPE_NCH-1:0] pd_cfg = {ctrl[`SSPE_CTRL_PD_WLAN], ctrl[`SSPE_CTRL_PD_SRR]};
  wire [`SSPE_NCH-1:0] pwr_pins = {wireless_lan_power_enable_i,
                                   short_range_radio_power_enable_i};

  // Unmapped offsets read zero and ignore writes
  assign rd_mux =
    (a_off == `SSPE_OFF_STATUS) ? {22'h0, in_done, strap_q} :
    (a_off == `SSPE_OFF_CTRL) ? {28'h0, ctrl} :
    (a_off == `SSPE_OFF_GPIO_OUT) ? {24'h0, gpio_out} :
    (a_off == `SSPE_OFF_GPIO_OE) ? {24'h0, gpio_oe} :
    (a_off == `SSPE_OFF_GPIO_IN) ? {23'h0, pad_i} :
    (a_off == `SSPE_OFF_PWR) ? {28'h0, section_rst_n_o, pwr_pins} :
    32'h0;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wr_pend <= 1'b0;
      wr_off <= 8'h0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (clk_en_i) begin
      wr_pend <= wr_take;
      if (wr_take) begin
        wr_off <= a_off;
      end
      if (addr_ph && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
      // Zero wait states: every register answers in its data phase
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ctrl <= `SSPE_CTRL_RESET;
      gpio_out <= 8'h0;
      gpio_oe <= 8'h0;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        ctrl <= hwdata_i[`SSPE_CTRL_W-1:0];
      end
      if (wr_gout) begin
        gpio_out <= hwdata_i[`SSPE_GPIO_W-1:0];
      end
      if (wr_goe) begin
        gpio_oe <= hwdata_i[`SSPE_GPIO_W-1:0];
      end
    end
  end

  // ****************************************
  // Strap decode and pad control
  // ****************************************
  // Pads stay inputs until sampling so the board straps are read cleanly
  wire [`SSPE_PAD_W-1:0] next_pad_oe = next_valid ? {1'b1, gpio_oe} : '0;
  wire xtal_level = osc_req ^ next_straps[`SSPE_PAD_XTAL];
  wire [`SSPE_PAD_W-1:0] next_pad_out = next_valid ? {xtal_level, gpio_out} : '0;
  wire [1:0] next_host = next_straps[`SSPE_PAD_HOST_HI:`SSPE_PAD_HOST_LO];
  wire [1:0] next_lvl = next_straps[`SSPE_PAD_LVL_HI:`SSPE_PAD_LVL_LO];
  // Pulls restate the strap defaults, so an unfitted strap reads as its default

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pad_o <= '0;
      pad_oe_o <= '0;
      pad_pu_o <= `SSPE_STRAP_DEFAULTS;
      pad_pd_o <= ~`SSPE_STRAP_DEFAULTS;
    end else if (clk_en_i) begin
      pad_o <= next_pad_out;
      pad_oe_o <= next_pad_oe;
      pad_pu_o <= `SSPE_STRAP_DEFAULTS;
      pad_pd_o <= ~`SSPE_STRAP_DEFAULTS;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      straps_valid_o <= 1'b0;
      host_ifc_mode_o <= `SSPE_HOST_USB;
      bootloader_skip_o <= 1'b0;
      fuse_mem_power_o <= 1'b0;
      flash_present_o <= 1'b0;
      flash_vendor_o <= 1'b0;
      boot_from_rom_o <= 1'b0;
      cpu_hold_reset_o <= 1'b1;
      resource_level_o <= `SSPE_LVL_NONE;
    end else if (clk_en_i) begin
      straps_valid_o <= next_valid;
      host_ifc_mode_o <= next_valid ? next_host : `SSPE_HOST_USB;
      bootloader_skip_o <= next_valid && (next_host == `SSPE_HOST_USB_NOBOOT);
      fuse_mem_power_o <= next_valid && next_straps[`SSPE_PAD_FUSE];
      flash_present_o <= next_valid && next_straps[`SSPE_PAD_FLASH_PRES];
      flash_vendor_o <= next_valid && next_straps[`SSPE_PAD_FLASH_VEND];
      boot_from_rom_o <= next_valid && next_straps[`SSPE_PAD_REMAP];
      // Processor waits for software in either boot mode
      cpu_hold_reset_o <= !(next_valid && cpu_run);
      resource_level_o <= next_valid ? next_lvl : `SSPE_LVL_NONE;
    end
  end

  // ****************************************
  // Section power gates
  // ****************************************
  // Enables are trusted synchronous; level 11 relies on the board's oscillator
  for (genvar ch = 0; ch < `SSPE_NCH; ch++) begin : g_gate
    sspe_power_gate i_sspe_power_gate (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .clk_en_i(clk_en_i),
      .pwr_en_i(pwr_pins[ch]),
      .pd_cfg_i(pd_cfg[ch]),
      .reg_en_o(reg_en_o[ch]),
      .section_rst_n_o(section_rst_n_o[ch]),
      .pd_en_o(pwr_pd_en_o[ch])
    );
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i iff clk_en_i);
  endclocking
  default disable iff (!resetn_i);

  sample_point_a: assert property (
    sample_now |=> in_done && straps_valid_o && (strap_q == $past(pad_i)))
    else $error("straps not captured at end of delay");
  delay_count_a: assert property (
    in_count && !cnt_last && !por_active |=> in_count && (cnt == $past(cnt) + CW'(1)))
    else $error("sampling delay counter did not advance");
  straps_hold_a: assert property (
    in_done && !por_active |=> $stable(strap_q))
    else $error("latched straps changed after sampling");
  pad_release_a: assert property (
    !straps_valid_o |-> (pad_oe_o == '0) && (pad_o == '0))
    else $error("pad driven before straps sampled");
  host_mode_a: assert property (
    straps_valid_o |-> (host_ifc_mode_o == strap_q[`SSPE_PAD_HOST_HI:`SSPE_PAD_HOST_LO])
      && (bootloader_skip_o ==
        (strap_q[`SSPE_PAD_HOST_HI:`SSPE_PAD_HOST_LO] == `SSPE_HOST_USB_NOBOOT)))
    else $error("host interface mode mismatch");
  fuse_power_a: assert property (
    !(straps_valid_o && strap_q[`SSPE_PAD_FUSE]) |-> !fuse_mem_power_o)
    else $error("fuse memory powered without strap");
  flash_straps_a: assert property (
    straps_valid_o |-> (flash_present_o == strap_q[`SSPE_PAD_FLASH_PRES])
      && (flash_vendor_o == strap_q[`SSPE_PAD_FLASH_VEND]))
    else $error("flash strap outputs mismatch");
  boot_remap_a: assert property (
    straps_valid_o |-> boot_from_rom_o == strap_q[`SSPE_PAD_REMAP])
    else $error("boot source mismatch");
  cpu_hold_a: assert property (
    !cpu_run |=> cpu_hold_reset_o)
    else $error("processor released without software");
  resource_level_a: assert property (
    straps_valid_o |-> resource_level_o == strap_q[`SSPE_PAD_LVL_HI:`SSPE_PAD_LVL_LO])
    else $error("resource level mismatch");
  xtal_polarity_a: assert property (
    pad_oe_o[`SSPE_PAD_XTAL] |->
      pad_o[`SSPE_PAD_XTAL] == ($past(osc_req) ^ strap_q[`SSPE_PAD_XTAL]))
    else $error("oscillator enable polarity wrong");
  pulldown_cfg_a: assert property (
    ##1 pwr_pd_en_o == $past(pd_cfg))
    else $error("pull-down enable does not follow control");

  // Restart and idle checks: a new power-on must look like the first one
  por_restart_a: assert property (
    por_active |=> !in_count && !straps_valid_o && (pad_oe_o == '0))
    else $error("external reset did not restart sampling");
  count_start_a: assert property (
    (state == sspe_pkg::sspe_st_wait) && !por_active |=> in_count && (cnt == '0))
    else $error("sampling delay did not start from zero");
  decode_idle_a: assert property (
    !straps_valid_o |-> (host_ifc_mode_o == `SSPE_HOST_USB) && !bootloader_skip_o
      && !fuse_mem_power_o && !flash_present_o && !flash_vendor_o && !boot_from_rom_o
      && cpu_hold_reset_o && (resource_level_o == `SSPE_LVL_NONE))
    else $error("decoded straps active before sampling");

  // Register side: pads, status and control as software sees them
  pad_drive_a: assert property (
    straps_valid_o |-> (pad_oe_o[`SSPE_GPIO_W-1:0] == $past(gpio_oe))
      && (pad_o[`SSPE_GPIO_W-1:0] == $past(gpio_out)))
    else $error("general-purpose pad function not restored");
  status_read_a: assert property (
    addr_ph && !hwrite_i && (a_off == `SSPE_OFF_STATUS) |=>
      hrdata_o == {22'h0, $past(in_done), $past(strap_q)})
    else $error("status read does not show latched straps");
  ctrl_write_a: assert property (
    wr_ctrl |=> ctrl == $past(hwdata_i[`SSPE_CTRL_W-1:0]))
    else $error("control write not stored");

  sample_done_c: cover property (sample_now);
  xtal_active_low_c: cover property (pad_oe_o[`SSPE_PAD_XTAL] && strap_q[`SSPE_PAD_XTAL]);
  resample_c: cover property (in_done ##1 por_active);
  cpu_release_c: cover property ($fell(cpu_hold_reset_o));

endmodule // sspe_top
`default_nettype wire

// File: testbench/sspe_board_model.sv
// Board strap resistors and host power-control lines
`timescale 1ns/100ps
`default_nettype none
module sspe_board_model (
  input wire logic core_clk_i,
  input wire logic [8:0] strap_val_i,
  input wire logic [8:0] strap_fit_i,
  input wire logic [8:0] pad_drv_i,
  input wire logic [8:0] pad_oe_i,
  input wire logic [8:0] pad_pu_i,
  input wire logic [8:0] pad_pd_i,
  output logic [8:0] pad_lvl_o,
  input wire logic [1:0] host_drv_i,
  input wire logic [1:0] host_lvl_i,
  input wire logic [1:0] pd_en_i,
  output logic [1:0] pwr_en_o
);
  // Undriven unpulled lines toggle, so no stale level passes as valid
  logic float_q = 1'b0;
  always @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int b = 0; b < 9; b++) begin
      if (pad_oe_i[b]) pad_lvl_o[b] = pad_drv_i[b];
      else if (strap_fit_i[b]) pad_lvl_o[b] = strap_val_i[b];
      else if (pad_pu_i[b]) pad_lvl_o[b] = 1'b1;
      else if (pad_pd_i[b]) pad_lvl_o[b] = 1'b0;
      else pad_lvl_o[b] = float_q;
    end
    for (int c = 0; c < 2; c++) begin
      if (host_drv_i[c]) pwr_en_o[c] = host_lvl_i[c];
      else if (pd_en_i[c]) pwr_en_o[c] = 1'b0;
      else pwr_en_o[c] = float_q;
    end
  end
endmodule // sspe_board_model
`default_nettype wire

// File: testbench/strap_sampling_power_enable_test.sv
// Self-checking bench for the strap sampling and power enable block
`timescale 1ns/100ps
`default_nettype none
`include "sspe_consts.svh"
module strap_sampling_power_enable_test;
  logic clk = 1'b0, rstn = 1'b0, ext_por = 1'b1, hsel = 1'b0, hwrite = 1'b0, clk_en = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'h0, host_drv = 2'h0, host_lvl = 2'h0, pwr, reg_en, rst_n, pd_en;
  logic [2:0] hsize = 3'h2;
  logic [8:0] strap_val = 9'h0, strap_fit = 9'h0, pad_i, pad_o, pad_oe, pad_pu, pad_pd;
  logic hready, hresp, valid, skip, fuse, pres, vend, rom, hold;
  logic [1:0] host, lvl;
  int fails = 0, num_checks = 0, n;
  logic [8:0] tbl [4] = '{9'h1a4, 9'h051, 9'h1f7, 9'h002};
  always #5 clk = ~clk;
  sspe_top #(.SAMPLE_DELAY_CYCLES(16)) i_sspe_top (.core_clk_i(clk), .resetn_i(rstn),
    .clk_en_i(clk_en), .ext_por_n_i(ext_por), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe), .pad_pu_o(pad_pu), .pad_pd_o(pad_pd),
    .straps_valid_o(valid), .host_ifc_mode_o(host), .bootloader_skip_o(skip),
    .fuse_mem_power_o(fuse), .flash_present_o(pres), .flash_vendor_o(vend),
    .boot_from_rom_o(rom), .cpu_hold_reset_o(hold), .resource_level_o(lvl),
    .short_range_radio_power_enable_i(pwr[0]), .wireless_lan_power_enable_i(pwr[1]),
    .reg_en_o(reg_en), .section_rst_n_o(rst_n), .pwr_pd_en_o(pd_en));
  sspe_board_model i_sspe_board_model (.core_clk_i(clk), .strap_val_i(strap_val),
    .strap_fit_i(strap_fit), .pad_drv_i(pad_o), .pad_oe_i(pad_oe), .pad_pu_i(pad_pu),
    .pad_pd_i(pad_pd), .pad_lvl_o(pad_i), .host_drv_i(host_drv), .host_lvl_i(host_lvl),
    .pd_en_i(pd_en), .pwr_en_o(pwr));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k >= 100) begin
      fails++;
      wrap_up;
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    d = hrdata;
  endtask
  task automatic wait_valid;
    n = 0;
    while (valid !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      fails++;
      wrap_up;
    end
  endtask
  task automatic check_straps(input logic [8:0] s);
    check(32'(host), 32'(s[3:2]));
    check(32'(skip), 32'(s[3:2] == 2'h1));
    check(32'(fuse), 32'(s[4]));
    check(32'({pres, vend}), 32'({s[5], s[7]}));
    check(32'(rom), 32'(s[6]));
    check(32'(lvl), 32'(s[1:0]));
    ahb(1'b0, {24'h0, `SSPE_OFF_STATUS}, 32'h0);
    check(d, {22'h0, 1'b1, s});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(32'({pd_en, hold, valid}), 32'h0e);
    check(32'({hready, hresp, pad_pu, pad_pd}),
      32'({1'b1, 1'b0, `SSPE_STRAP_DEFAULTS, ~`SSPE_STRAP_DEFAULTS}));
    wait_valid;
    check(32'(n >= 16), 32'h1);
    check_straps(9'h052);
    // Pins change after sampling; latched values must not follow
    strap_fit <= 9'h0ff;
    strap_val <= 9'h1ff;
    repeat (4) @(posedge clk);
    check_straps(9'h052);
    ahb(1'b1, {24'h0, `SSPE_OFF_GPIO_OE}, 32'hff);
    ahb(1'b1, {24'h0, `SSPE_OFF_GPIO_OUT}, 32'ha5);
    repeat (2) @(posedge clk);
    check(32'({pad_oe, pad_o[7:0]}), 32'h1ffa5);
    ahb(1'b0, {24'h0, `SSPE_OFF_GPIO_IN}, 32'h0);
    check(d, 32'h0a5);
    ahb(1'b0, 32'h40, 32'h0);
    check(d, 32'h0);
    foreach (tbl[i]) begin
      strap_fit <= 9'h1ff;
      // Level 11 entry stands for a board with a 30 MHz oscillator
      strap_val <= tbl[i];
      ext_por <= 1'b0;
      repeat (2) @(posedge clk);
      check(32'(valid), 32'h0);
      ext_por <= 1'b1;
      wait_valid;
      check(32'(n >= 16), 32'h1);
      check_straps(tbl[i]);
      ahb(1'b1, {24'h0, `SSPE_OFF_CTRL}, 32'h3);
      repeat (2) @(posedge clk);
      check(32'({pad_o[8], hold}), 32'({tbl[i][8], 1'b1}));
      ahb(1'b1, {24'h0, `SSPE_OFF_CTRL}, 32'hf);
      repeat (2) @(posedge clk);
      check(32'({pad_o[8], hold, pad_oe[8]}), 32'({~tbl[i][8], 2'h1}));
    end
    for (int c = 0; c < 2; c++) begin
      host_drv[c] <= 1'b1;
      host_lvl[c] <= 1'b1;
      repeat (2) @(posedge clk);
      check(32'({reg_en[c], rst_n[c]}), 32'h2);
      @(posedge clk);
      check(32'(rst_n[c]), 32'h1);
      ahb(1'b0, {24'h0, `SSPE_OFF_PWR}, 32'h0);
      check(d, 32'h5 << c);
      host_lvl[c] <= 1'b0;
      repeat (2) @(posedge clk);
      check(32'({reg_en[c], rst_n[c]}), 32'h0);
    end
    // A low clock enable must hold every flop, section power included
    clk_en <= 1'b0;
    host_lvl <= 2'h3;
    repeat (3) @(posedge clk);
    check(32'({reg_en, rst_n, valid}), 32'h1);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(reg_en), 32'h3);
    host_lvl <= 2'h0;
    ahb(1'b1, {24'h0, `SSPE_OFF_CTRL}, 32'h0);
    host_drv <= 2'h0;
    repeat (2) @(posedge clk);
    check(32'(pd_en), 32'h0);
    wrap_up;
  end
endmodule // strap_sampling_power_enable_test
`default_nettype wire
